// File: core/tcp_map.svh
`ifndef TCP_MAP_SVH
`define TCP_MAP_SVH

// Register offsets on the byte-wide register port.
`define TCP_ADDR_W 4
`define TCP_OFF_TIMER_CTRL 4'h0
`define TCP_OFF_COUNT_HI 4'h1
`define TCP_OFF_COUNT_LO 4'h2
`define TCP_OFF_LIMIT_HI 4'h3
`define TCP_OFF_LIMIT_LO 4'h4
`define TCP_OFF_CH0_CTRL 4'h5
`define TCP_OFF_CH0_VAL_HI 4'h6
`define TCP_OFF_CH0_VAL_LO 4'h7
`define TCP_OFF_CH1_CTRL 4'h8
`define TCP_OFF_CH1_VAL_HI 4'h9
`define TCP_OFF_CH1_VAL_LO 4'hA

// Timer control and status fields.
`define TCP_TC_WRAP_FLAG 7
`define TCP_TC_WRAP_IE 6
`define TCP_TC_HALT 5
`define TCP_TC_CRST 4
`define TCP_TC_PS_HI 2
`define TCP_TC_PS_LO 0

// Channel control and status fields.
`define TCP_CH_FLAG 7
`define TCP_CH_IE 6
`define TCP_CH_MODE_HI 5
`define TCP_CH_MODE_LO 4
`define TCP_CH_ELS_HI 3
`define TCP_CH_ELS_LO 2
`define TCP_CH_TOV 1
`define TCP_CH_FULL 0

// Reset values and widths.
`define TCP_HALT_RST 1'h1
`define TCP_LIMIT_RST 16'hFFFF
`define TCP_VALUE_RST 16'h0000
`define TCP_PRESCALE_W 6
`define TCP_PS_NONE 3'h7

`endif

// File: core/tcp_pkg.sv
package tcp_pkg;

    // Per-channel output configuration as held in a channel control register.
    typedef struct packed {
        logic mode_sel_hi;
        logic mode_sel_lo;
        logic edge_level_hi;
        logic edge_level_lo;
        logic overflow_toggle_en;
        logic full_duty_force;
    } tcp_chan_cfg_t;

    // Timer events that drive a channel pin.
    typedef struct packed {
        logic wrap;
        logic match;
    } tcp_chan_evt_t;

    typedef enum logic [1:0] {
        TCP_ACT_NONE,
        TCP_ACT_TOGGLE,
        TCP_ACT_CLEAR,
        TCP_ACT_SET
    } tcp_action_t;

endpackage

// File: core/tcp_chan_out.sv
`timescale 1ns/1ps

module tcp_chan_out
(
    input wire logic i_clock,
    input wire logic i_arst_n,
    input wire tcp_pkg::tcp_chan_cfg_t i_cfg,
    input wire tcp_pkg::tcp_chan_evt_t i_evt,
    input wire logic i_enable,
    output logic o_pin,
    output logic o_pin_oe
);

    function automatic tcp_pkg::tcp_action_t action_of(input tcp_pkg::tcp_chan_cfg_t cfg);
        case ({cfg.edge_level_hi, cfg.edge_level_lo})
            2'h1: action_of = tcp_pkg::TCP_ACT_TOGGLE;
            2'h2: action_of = tcp_pkg::TCP_ACT_CLEAR;
            2'h3: action_of = tcp_pkg::TCP_ACT_SET;
            default: action_of = tcp_pkg::TCP_ACT_NONE;
        endcase
    endfunction

    logic pin_q;
    logic pin_d;
    logic oe_q;
    logic out_mode;
    logic pulse_level;
    logic forced_full;
    tcp_pkg::tcp_action_t act;

    assign act = action_of(i_cfg);
    assign out_mode = (i_cfg.mode_sel_hi | i_cfg.mode_sel_lo) & (act != tcp_pkg::TCP_ACT_NONE);
    // The pulse level is the complement of what the compare drives.
    assign pulse_level = (act != tcp_pkg::TCP_ACT_SET);
    assign forced_full = i_cfg.full_duty_force & i_cfg.overflow_toggle_en;

    always_comb
    begin
        pin_d = pin_q;
        if (i_enable && out_mode)
        begin
            if (i_evt.wrap && i_cfg.overflow_toggle_en) // R8 R16
            begin
                pin_d = forced_full ? pulse_level : ~pin_q; // R17 R22
            end
            if (i_evt.match && !forced_full) // R19 R22
            begin
                case (act)
                    tcp_pkg::TCP_ACT_TOGGLE: pin_d = ~pin_d;
                    tcp_pkg::TCP_ACT_CLEAR: pin_d = 1'b0; // R15
                    tcp_pkg::TCP_ACT_SET: pin_d = 1'b1; // R15
                    default: pin_d = pin_d;
                endcase
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            pin_q <= 1'b0;
        end
        else
        begin
            pin_q <= pin_d;
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            oe_q <= 1'b0;
        end
        else
        begin
            oe_q <= i_enable & out_mode;
        end
    end

    assign o_pin = pin_q;
    assign o_pin_oe = oe_q;

endmodule

// File: core/tcp_top.sv
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "tcp_map.svh"

// Notes on behaviour
// R1: Unbuffered compare uses a newly written value at once; a passed value misses.
// R2: Software writes a smaller unbuffered value from the compare handler.
// R3: Software writes a larger unbuffered value from the wrap handler.
// R4: Channel 0 pairing bit links both channels; output only on channel 0 pin.
// R5: When linked, control moves at each wrap to the pair written last.
// R6: While linked channel 0 control reports; channel 1 pin is released.
// R7: Writing the active pair while linked acts like unbuffered operation.
// R8: With wrap toggle enabled the pin toggles at every counter wrap.
// R9: Software picks clear-on-compare for high pulses, set for low pulses.
// R10: PWM period is the period limit plus one counter clocks.
// R11: Duty is compare value over period in counter clocks.
// R12: Software avoids toggle-on-compare for PWM.
// R13: Software halts, resets, loads limit, value, mode, then releases the halt.
// R14: Mode bits 0:1 select unbuffered, 1:0 buffered compare or PWM.
// R15: Edge bits 1:0 clear and 1:1 set the pin on compare.
// R16: Without wrap toggle compares hold the pin level, giving 0% duty.
// R17: Full-duty bit with wrap toggle gives 100% duty.
// R18: Unsynchronised value writes are not guarded; errors may last two periods.
// R19: A compare match sets, clears or toggles the pin per edge bits.
// R20: At the period limit the wrap flag sets and the counter restarts at zero.
// R21: Counter reset bit clears counter and prescaler, self-clears, reads zero.
// R22: Full-duty holds the pulse level and suppresses the ending compare.
// R23: Active pair returns to channel 0 on new linking or timer reset.
module tcp_top
(
    input wire logic i_clock,
    input wire logic i_arst_n,
    input wire logic [`TCP_ADDR_W-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    output logic o_chan0_pin,
    output logic o_chan0_pin_oe,
    output logic o_chan1_pin,
    output logic o_chan1_pin_oe,
    output logic o_wrap,
    output logic [15:0] o_count
);

    // Divide-by-2^sel tick from the free prescaler; the unused code never ticks.
    function automatic logic prescale_tick(input logic [2:0] sel,
                                           input logic [`TCP_PRESCALE_W-1:0] pre);
        case (sel)
            3'h0: prescale_tick = 1'b1;
            3'h1: prescale_tick = pre[0];
            3'h2: prescale_tick = &pre[1:0];
            3'h3: prescale_tick = &pre[2:0];
            3'h4: prescale_tick = &pre[3:0];
            3'h5: prescale_tick = &pre[4:0];
            3'h6: prescale_tick = &pre[5:0];
            default: prescale_tick = 1'b0;
        endcase
    endfunction

    function automatic logic wr_at(input logic wr, input logic [`TCP_ADDR_W-1:0] a,
                                   input logic [`TCP_ADDR_W-1:0] off);
        wr_at = wr && (a == off);
    endfunction

    logic halt_q;
    logic wrap_ie_q;
    logic [2:0] ps_q;
    logic wrap_flag_q;
    logic wrap_armed_q;
    logic [15:0] limit_q;
    logic limit_hold_q;
    logic [15:0] count_q;
    logic [15:0] count_d;
    logic [`TCP_PRESCALE_W-1:0] prescale_q;
    logic [7:0] count_lo_latch_q;
    logic count_latched_q;
    logic [1:0] chan_flag_q;
    logic [1:0] chan_armed_q;
    logic [1:0] chan_ie_q;
    logic [1:0] chan_hold_q;
    tcp_pkg::tcp_chan_cfg_t chan_cfg_q [2];
    logic [15:0] chan_val_q [2];
    logic active_q;
    logic last_written_q;
    logic link_seen_q;
    logic [7:0] rdata_q;

    logic counter_reset;
    logic tick;
    logic wrap;
    logic link;
    logic [1:0] match;
    logic [1:0] val_lo_wr;
    logic [1:0] ctrl_wr;
    logic [1:0] ctrl_rd;
    logic [15:0] cmp_val0;

    assign counter_reset = wr_at(i_wr, i_addr, `TCP_OFF_TIMER_CTRL) && i_wdata[`TCP_TC_CRST];
    assign tick = !halt_q && prescale_tick(ps_q, prescale_q);
    assign wrap = tick && (count_q == limit_q); // R20
    assign link = chan_cfg_q[0].mode_sel_hi; // R4 R14
    assign count_d = wrap ? 16'h0000 : count_q + 16'h0001; // R10
    assign ctrl_wr[0] = wr_at(i_wr, i_addr, `TCP_OFF_CH0_CTRL);
    assign ctrl_wr[1] = wr_at(i_wr, i_addr, `TCP_OFF_CH1_CTRL);
    assign ctrl_rd[0] = i_rd && (i_addr == `TCP_OFF_CH0_CTRL);
    assign ctrl_rd[1] = i_rd && (i_addr == `TCP_OFF_CH1_CTRL);
    assign val_lo_wr[0] = wr_at(i_wr, i_addr, `TCP_OFF_CH0_VAL_LO);
    assign val_lo_wr[1] = wr_at(i_wr, i_addr, `TCP_OFF_CH1_VAL_LO);
    // Writes to the active pair land here directly, so they act as unbuffered.
    assign cmp_val0 = (link && active_q) ? chan_val_q[1] : chan_val_q[0]; // R5 R7

    // A match is the counter stepping onto the value; a value already passed
    // simply waits for the next period, with no repair of a late write.
    assign match[0] = tick && !chan_hold_q[0] && !(link && chan_hold_q[1])
                      && (count_d == cmp_val0); // R1 R11 R18
    assign match[1] = tick && !link && !chan_hold_q[1]
                      && (count_d == chan_val_q[1]); // R1 R19

    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            halt_q <= `TCP_HALT_RST;
            wrap_ie_q <= 1'b0;
            ps_q <= 3'h0;
        end
        else if (wr_at(i_wr, i_addr, `TCP_OFF_TIMER_CTRL))
        begin
            halt_q <= i_wdata[`TCP_TC_HALT];
            wrap_ie_q <= i_wdata[`TCP_TC_WRAP_IE];
            ps_q <= i_wdata[`TCP_TC_PS_HI:`TCP_TC_PS_LO];
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            prescale_q <= '0;
            count_q <= 16'h0000;
        end
        else if (counter_reset) // R21
        begin
            prescale_q <= '0;
            count_q <= 16'h0000;
        end
        else if (!halt_q)
        begin
            prescale_q <= prescale_q + `TCP_PRESCALE_W'(1);
            if (tick)
            begin
                count_q <= count_d; // R20
            end
        end
    end

    // Wrap flag: cleared by reading it set then writing zero; a new wrap wins.
    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            wrap_flag_q <= 1'b0;
            wrap_armed_q <= 1'b0;
        end
        else if (wrap && !limit_hold_q) // R20
        begin
            wrap_flag_q <= 1'b1;
            wrap_armed_q <= 1'b0;
        end
        else if (wr_at(i_wr, i_addr, `TCP_OFF_TIMER_CTRL))
        begin
            if (wrap_armed_q && !i_wdata[`TCP_TC_WRAP_FLAG])
            begin
                wrap_flag_q <= 1'b0;
            end
            wrap_armed_q <= 1'b0;
        end
        else if (i_rd && (i_addr == `TCP_OFF_TIMER_CTRL) && wrap_flag_q)
        begin
            wrap_armed_q <= 1'b1;
        end
    end

    // The high limit byte holds off the wrap flag until the low byte follows.
    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            limit_q <= `TCP_LIMIT_RST;
            limit_hold_q <= 1'b0;
        end
        else if (wr_at(i_wr, i_addr, `TCP_OFF_LIMIT_HI))
        begin
            limit_q[15:8] <= i_wdata;
            limit_hold_q <= 1'b1;
        end
        else if (wr_at(i_wr, i_addr, `TCP_OFF_LIMIT_LO))
        begin
            limit_q[7:0] <= i_wdata;
            limit_hold_q <= 1'b0;
        end
    end

    // Reading the high count byte freezes the low byte until it is read.
    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            count_lo_latch_q <= 8'h00;
            count_latched_q <= 1'b0;
        end
        else if (i_rd && (i_addr == `TCP_OFF_COUNT_HI) && !count_latched_q)
        begin
            count_lo_latch_q <= count_q[7:0];
            count_latched_q <= 1'b1;
        end
        else if (i_rd && (i_addr == `TCP_OFF_COUNT_LO))
        begin
            count_latched_q <= 1'b0;
        end
    end

    generate
        for (genvar ch = 0; ch < 2; ch++)
        begin : g_chan
            always_ff @(posedge i_clock or negedge i_arst_n)
            begin
                if (!i_arst_n)
                begin
                    chan_ie_q[ch] <= 1'b0;
                    chan_cfg_q[ch] <= '0;
                end
                else if (ctrl_wr[ch])
                begin
                    chan_ie_q[ch] <= i_wdata[`TCP_CH_IE];
                    // Only channel 0 carries the pairing bit.
                    chan_cfg_q[ch].mode_sel_hi <= (ch == 0) ? i_wdata[`TCP_CH_MODE_HI] : 1'b0; // R4
                    chan_cfg_q[ch].mode_sel_lo <= i_wdata[`TCP_CH_MODE_LO]; // R14
                    chan_cfg_q[ch].edge_level_hi <= i_wdata[`TCP_CH_ELS_HI];
                    chan_cfg_q[ch].edge_level_lo <= i_wdata[`TCP_CH_ELS_LO];
                    chan_cfg_q[ch].overflow_toggle_en <= i_wdata[`TCP_CH_TOV];
                    chan_cfg_q[ch].full_duty_force <= i_wdata[`TCP_CH_FULL];
                end
            end

            // Channel flag follows the wrap flag clearing scheme; a match wins.
            always_ff @(posedge i_clock or negedge i_arst_n)
            begin
                if (!i_arst_n)
                begin
                    chan_flag_q[ch] <= 1'b0;
                    chan_armed_q[ch] <= 1'b0;
                end
                else if (match[ch])
                begin
                    chan_flag_q[ch] <= 1'b1;
                    chan_armed_q[ch] <= 1'b0;
                end
                else if (ctrl_wr[ch])
                begin
                    if (chan_armed_q[ch] && !i_wdata[`TCP_CH_FLAG])
                    begin
                        chan_flag_q[ch] <= 1'b0;
                    end
                    chan_armed_q[ch] <= 1'b0;
                end
                else if (ctrl_rd[ch] && chan_flag_q[ch])
                begin
                    chan_armed_q[ch] <= 1'b1;
                end
            end

            // A high value byte holds off compares until the low byte lands.
            always_ff @(posedge i_clock or negedge i_arst_n)
            begin
                if (!i_arst_n)
                begin
                    chan_val_q[ch] <= `TCP_VALUE_RST;
                    chan_hold_q[ch] <= 1'b0;
                end
                else if (wr_at(i_wr, i_addr, (ch == 0) ? `TCP_OFF_CH0_VAL_HI
                                                       : `TCP_OFF_CH1_VAL_HI))
                begin
                    chan_val_q[ch][15:8] <= i_wdata;
                    chan_hold_q[ch] <= 1'b1;
                end
                else if (val_lo_wr[ch])
                begin
                    chan_val_q[ch][7:0] <= i_wdata; // R1
                    chan_hold_q[ch] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            link_seen_q <= 1'b0;
        end
        else
        begin
            link_seen_q <= link;
        end
    end

    // Pair selection: last completed value write decides at the next wrap.
    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            active_q <= 1'b0;
            last_written_q <= 1'b0;
        end
        else if ((link && !link_seen_q) || counter_reset) // R23
        begin
            active_q <= 1'b0;
            last_written_q <= 1'b0;
        end
        else
        begin
            if (val_lo_wr[1])
            begin
                last_written_q <= 1'b1;
            end
            else if (val_lo_wr[0])
            begin
                last_written_q <= 1'b0;
            end
            if (wrap && link)
            begin
                active_q <= last_written_q; // R5
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            rdata_q <= 8'h00;
        end
        else if (i_rd)
        begin
            case (i_addr)
                `TCP_OFF_TIMER_CTRL: rdata_q <= {wrap_flag_q, wrap_ie_q, halt_q,
                                                 2'h0, ps_q}; // R21
                `TCP_OFF_COUNT_HI: rdata_q <= count_q[15:8];
                `TCP_OFF_COUNT_LO: rdata_q <= count_latched_q ? count_lo_latch_q
                                                              : count_q[7:0];
                `TCP_OFF_LIMIT_HI: rdata_q <= limit_q[15:8];
                `TCP_OFF_LIMIT_LO: rdata_q <= limit_q[7:0];
                `TCP_OFF_CH0_CTRL: rdata_q <= {chan_flag_q[0], chan_ie_q[0],
                                               chan_cfg_q[0]}; // R6
                `TCP_OFF_CH0_VAL_HI: rdata_q <= chan_val_q[0][15:8];
                `TCP_OFF_CH0_VAL_LO: rdata_q <= chan_val_q[0][7:0];
                `TCP_OFF_CH1_CTRL: rdata_q <= {chan_flag_q[1], chan_ie_q[1],
                                               chan_cfg_q[1]};
                `TCP_OFF_CH1_VAL_HI: rdata_q <= chan_val_q[1][15:8];
                `TCP_OFF_CH1_VAL_LO: rdata_q <= chan_val_q[1][7:0];
                default: rdata_q <= 8'h00;
            endcase
        end
        else
        begin
            rdata_q <= 8'h00;
        end
    end

    tcp_pkg::tcp_chan_evt_t evt0;
    tcp_pkg::tcp_chan_evt_t evt1;

    assign evt0 = '{wrap: wrap, match: match[0]};
    assign evt1 = '{wrap: wrap, match: match[1]};

    tcp_chan_out u_chan0
    (
        .i_clock(i_clock),
        .i_arst_n(i_arst_n),
        .i_cfg(chan_cfg_q[0]),
        .i_evt(evt0),
        .i_enable(1'b1),
        .o_pin(o_chan0_pin),
        .o_pin_oe(o_chan0_pin_oe)
    );

    // While linked, channel 1 lets go of its pin for general use.
    tcp_chan_out u_chan1
    (
        .i_clock(i_clock),
        .i_arst_n(i_arst_n),
        .i_cfg(chan_cfg_q[1]),
        .i_evt(evt1),
        .i_enable(!link), // R6
        .o_pin(o_chan1_pin),
        .o_pin_oe(o_chan1_pin_oe)
    );

    assign o_rdata = rdata_q;
    assign o_wrap = wrap;
    assign o_count = count_q;

endmodule

// File: test/tcp_chk.sv
`timescale 1ns/1ps

module tcp_chk
(
    input wire logic i_clock,
    input wire logic i_arst_n,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic o_chan0_pin,
    input wire logic o_chan0_pin_oe,
    input wire logic o_chan1_pin_oe,
    input wire logic o_wrap,
    input wire logic [15:0] o_count
);
    logic [5:0] cfg_q;
    logic [15:0] lim_q;
    logic [15:0] val_q;
    logic pend_q;
    logic [2:0] age_q;
    wire logic unb = age_q > 3'h2 && cfg_q[5:3] == 3'h3 && !cfg_q[0] && !pend_q;
    wire logic full = age_q > 3'h3 && cfg_q[5:3] == 3'h3 && cfg_q[1:0] == 2'h3;

    // Shadows of what software wrote, since the design's registers are hidden here.
    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            cfg_q <= 6'h00;
            val_q <= 16'h0000;
            pend_q <= 1'b0;
        end
        else if (i_wr)
        begin
            if (i_addr == 4'h5)
                cfg_q <= i_wdata[5:0];
            if (i_addr == 4'h6)
                val_q[15:8] <= i_wdata;
            if (i_addr == 4'h7)
                val_q[7:0] <= i_wdata;
            if (i_addr == 4'h6 || i_addr == 4'h7)
                pend_q <= i_addr == 4'h6;
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
            lim_q <= 16'hFFFF;
        else if (i_wr && i_addr == 4'h3)
            lim_q[15:8] <= i_wdata;
        else if (i_wr && i_addr == 4'h4)
            lim_q[7:0] <= i_wdata;
    end

    // Cycles since the last channel 0 write, so checks skip the settling edge.
    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
            age_q <= 3'h0;
        else if (i_wr && i_addr > 4'h4 && i_addr < 4'h8)
            age_q <= 3'h0;
        else if (age_q != 3'h7)
            age_q <= age_q + 3'h1;
    end

    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_arst_n);

    sequence s_hit;
        o_count == val_q && ($past(o_count) + 16'h1 == o_count || $past(o_wrap));
    endsequence

    property p_wrap;
        o_wrap |-> o_count == lim_q ##1 o_count == 16'h0000;
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap not at limit");

    property p_crst;
        i_wr && i_addr == 4'h0 && i_wdata[4] |=> o_count == 16'h0000;
    endproperty
    a_crst: assert property (p_crst) else $error("counter not cleared");

    property p_link;
        age_q > 3'h2 && cfg_q[5] |-> !o_chan1_pin_oe;
    endproperty
    a_link: assert property (p_link) else $error("chan1 driven while linked");

    property p_oe;
        age_q > 3'h2 |-> o_chan0_pin_oe == (cfg_q[5:4] != 2'h0 && cfg_q[3:2] != 2'h0);
    endproperty
    a_oe: assert property (p_oe) else $error("chan0 enable wrong");

    property p_match;
        unb ##0 s_hit |-> o_chan0_pin == cfg_q[2];
    endproperty
    a_match: assert property (p_match) else $error("compare action wrong");

    property p_tov;
        unb && cfg_q[1] && val_q != 16'h0000 && o_wrap |=> o_chan0_pin != $past(o_chan0_pin);
    endproperty
    a_tov: assert property (p_tov) else $error("no toggle at wrap");

    property p_zero;
        unb && !cfg_q[1] && !cfg_q[2] |-> !$rose(o_chan0_pin);
    endproperty
    a_zero: assert property (p_zero) else $error("pin rose without toggle");

    property p_full;
        full && o_wrap |=> o_chan0_pin == !cfg_q[2];
    endproperty
    a_full: assert property (p_full) else $error("full duty level wrong");

    property p_hold;
        full && !$past(o_wrap) |-> $stable(o_chan0_pin);
    endproperty
    a_hold: assert property (p_hold) else $error("full duty pulse ended");
endmodule

bind tcp_top tcp_chk u_chk (.i_clock, .i_arst_n, .i_addr, .i_wdata, .i_wr, .o_chan0_pin,
    .o_chan0_pin_oe, .o_chan1_pin_oe, .o_wrap, .o_count);

// File: test/tcp_load.sv
`timescale 1ns/1ps

// Load with a weak pull-down; reports the last rise-to-rise period and its high time.
module tcp_load
(
    input wire logic i_clock,
    input wire logic i_pin,
    input wire logic i_oe,
    output int o_per,
    output int o_hi
);
    int per_q = 0;
    int hi_q = 0;
    logic lvl_q = 1'b0;
    wire logic lvl = i_oe & i_pin;

    always @(posedge i_clock)
    begin
        lvl_q <= lvl;
        per_q <= per_q + 1;
        hi_q <= hi_q + int'(lvl);
        if (lvl && !lvl_q)
        begin
            o_per <= per_q;
            o_hi <= hi_q;
            per_q <= 1;
            hi_q <= 1;
        end
    end
endmodule

// File: test/tcp_top_tb_top.sv
`timescale 1ns/1ps

module tcp_top_tb_top;
    logic i_clock = 1'b0;
    logic i_arst_n = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [7:0] o_rdata;
    logic o_chan0_pin;
    logic o_chan0_pin_oe;
    logic o_chan1_pin;
    logic o_chan1_pin_oe;
    logic o_wrap;
    logic [15:0] o_count;
    int per;
    int hi;
    int num_errors = 0;
    int n_compared = 0;
    int seed = 32'h1c59f44a;
    int c;
    logic [7:0] rv;
    logic [15:0] lim;
    logic [15:0] val;

    always #2.5 i_clock = ~i_clock;

    tcp_top dut (.i_clock, .i_arst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_chan0_pin,
        .o_chan0_pin_oe, .o_chan1_pin, .o_chan1_pin_oe, .o_wrap, .o_count);
    tcp_load u_load (.i_clock, .i_pin(o_chan0_pin), .i_oe(o_chan0_pin_oe), .o_per(per),
        .o_hi(hi));

    function automatic logic [15:0] f_hi(input logic [15:0] l, input logic [15:0] v,
        input logic low);
        return low ? l + 16'h1 - v : v;
    endfunction

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clock);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge i_clock);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask

    // Bounded wait for k wraps; a hang ends the run rather than stalling it.
    task automatic wait_wrap(input int k);
        int t = 0;
        while (k > 0)
        begin
            @(posedge i_clock);
            t++;
            if (o_wrap === 1'b1)
                k--;
            if (t > 20000)
            begin
                num_errors++;
                complete_run;
            end
        end
        repeat (2) @(posedge i_clock);
    endtask

    task automatic cnt_lvl(input int cyc, input logic lv, output int n);
        n = 0;
        repeat (cyc)
        begin
            @(posedge i_clock);
            if (o_chan0_pin === lv)
                n++;
        end
    endtask

    task automatic setup(input logic [15:0] l, input logic [15:0] v, input logic [7:0] cf);
        wr(4'h0, 8'h30);
        wr(4'h3, l[15:8]);
        wr(4'h4, l[7:0]);
        wr(4'h6, v[15:8]);
        wr(4'h7, v[7:0]);
        wr(4'h5, cf);
        wr(4'h0, 8'h00);
    endtask

    task automatic pwm(input logic [15:0] l, input logic [15:0] v, input logic low);
        setup(l, v, low ? 8'h1E : 8'h1A);
        wait_wrap(4);
        chk("period", 16'(per), l + 16'h1);
        chk("high", 16'(hi), f_hi(l, v, low));
    endtask

    initial
    begin
        repeat (5) @(posedge i_clock);
        i_arst_n <= 1'b1;
        rd(4'h0, rv);
        chk("tctrl", 16'(rv), 16'h0020);
        rd(4'h3, rv);
        chk("lim_hi", 16'(rv), 16'h00FF);
        wr(4'hB, 8'h5A);
        rd(4'hB, rv);
        chk("unmapped", 16'(rv), 16'h0000);
        pwm(16'h00FF, 16'h0080, 1'b0);
        pwm(16'h0007, 16'h0001, 1'b0);
        pwm(16'h0007, 16'h0007, 1'b1);
        wr(4'h0, 8'h01);
        wait_wrap(3);
        chk("per_div2", 16'(per), 16'h0010);
        pwm(16'h001F, 16'h0010, 1'b0);
        wr(4'h7, 8'h18);
        wait_wrap(3);
        chk("larger", 16'(hi), 16'h0018);
        repeat (26) @(posedge i_clock);
        wr(4'h7, 8'h06);
        wait_wrap(3);
        chk("smaller", 16'(hi), 16'h0006);
        for (int i = 0; i < 6; i++)
        begin
            rv = 8'($random(seed));
            lim = 16'(rv[4:0]) + 16'h4;
            rv = 8'($random(seed));
            val = 16'(rv) % lim + 16'h1;
            pwm(lim, val, i[0]);
        end
        setup(16'h0009, 16'h0003, 8'h18);
        wait_wrap(2);
        cnt_lvl(30, 1'b1, c);
        chk("zero_duty", 16'(c), 16'h0000);
        setup(16'h0009, 16'h0003, 8'h1B);
        wait_wrap(2);
        cnt_lvl(30, 1'b0, c);
        chk("full_duty", 16'(c), 16'h0000);
        wr(4'h8, 8'h1B);
        wait_wrap(1);
        chk("ch1_full", 16'(o_chan1_pin), 16'h0001);
        setup(16'h000F, 16'h0004, 8'h2A);
        wait_wrap(4);
        chk("link_first", 16'(hi), 16'h0004);
        chk("ch1_oe", 16'(o_chan1_pin_oe), 16'h0000);
        chk("ch1_hold", 16'(o_chan1_pin), 16'h0001);
        wr(4'h9, 8'h00);
        wr(4'hA, 8'h0B);
        wait_wrap(4);
        chk("link_ch1", 16'(hi), 16'h000B);
        wr(4'h6, 8'h00);
        wr(4'h7, 8'h02);
        wait_wrap(4);
        chk("link_ch0", 16'(hi), 16'h0002);
        wr(4'h0, 8'h30);
        #1 chk("count", o_count, 16'h0000);
        rd(4'h0, rv);
        chk("crst_rd", 16'(rv[4]), 16'h0000);
        complete_run;
    end
endmodule
